// [shared/evt_pkg.sv]
/*
  constants and encodings for the event counter, interval timer and output off-delay logic.
  assumes a single 250 MHz clock and configuration inputs that are held stable by the host.
*/
// Function
// R01: counter end code 0..3, default 3; 1 stop-hold, 2 cycle-pulse, 3 cycle, halt on stop
// R02: counter start 0 counts from power-on, 1 only while drive runs; default 1
// R03: count reaching reset value pulses counter-reset output and clears counter; default 0
// R04: detection value limited to reset value, never above; default 0
// R05: timer end code 0 stop-release, 1 stop-hold, 2 cycle-release, 3 cycle-hold; default 3
// R06: timer start 0 always runs, 1 runs only while drive runs; default 1
// R07: timer interval in whole seconds 0..65535, default 0
// R08: each switch and relay output follows its source after own 0.0..100.0 s delay
// R09: count reaching detection value pulses a separate counter-detection output
// R10: counter end code 0 stops counting and releases the output
package evt_pkg;
  localparam int CNT_W = 16;
  localparam int TMR_W = 16;
  localparam int DLY_W = 10;
  localparam int NUM_OUT = 4;
  localparam int CLK_MHZ = 250;
  localparam int TENTH_US = 100000;
  localparam int TENTH_CYCLES_DEF = TENTH_US * CLK_MHZ;
  localparam logic [3:0] TENTHS_PER_SEC = 4'hA;
  localparam logic [DLY_W-1:0] DLY_MAX = 10'h3E8;
  localparam logic [DLY_W-1:0] DLY_DEF = 10'h000;
  localparam logic [CNT_W-1:0] CNT_RESET_DEF = 16'h0000;
  localparam logic [CNT_W-1:0] CNT_DETECT_DEF = 16'h0000;
  localparam logic [TMR_W-1:0] TMR_INTERVAL_DEF = 16'h0000;

  typedef enum logic [1:0] {
    END_STOP_OFF = 2'b00,
    END_STOP_HOLD = 2'b01,
    END_CYCLE_OFF = 2'b10,
    END_CYCLE_HOLD = 2'b11
  } end_mode_type;

  typedef enum logic {
    START_ALWAYS = 1'b0,
    START_RUN = 1'b1
  } start_type;

  typedef enum logic [1:0] {
    SRC_NONE = 2'b00,
    SRC_CNT_RESET = 2'b01,
    SRC_CNT_DETECT = 2'b10,
    SRC_TMR_REACH = 2'b11
  } out_src_type;

  localparam end_mode_type CNT_MODE_DEF = END_CYCLE_HOLD;
  localparam end_mode_type TMR_MODE_DEF = END_CYCLE_HOLD;
  localparam start_type CNT_START_DEF = START_RUN;
  localparam start_type TMR_START_DEF = START_RUN;
endpackage : evt_pkg

// [core/off_delay.sv]
/*
  one output terminal: copies its source level to the pin after a programmable delay in tenths.
  assumes a one-cycle tenth-second tick from the same clock domain.
*/
`timescale 1ns/1ps
module off_delay (
  input wire logic clk,
  input wire logic nrst,
  input wire logic tick,
  input wire logic level_in,
  input wire logic [evt_pkg::DLY_W-1:0] delay_tenths,
  output logic level_out
);
  import evt_pkg::*;

  typedef struct packed {
    logic out;
    logic [DLY_W-1:0] cnt;
  } state_type;

  state_type s_r;
  state_type s_nxt;
  logic [DLY_W-1:0] dly_eff;

  assign dly_eff = (delay_tenths > DLY_MAX) ? DLY_MAX : delay_tenths;

  always_comb begin
    s_nxt = s_r;
    if (level_in == s_r.out) begin
      s_nxt.cnt = '0;
    end else if (s_r.cnt >= dly_eff) begin
      s_nxt.out = level_in; // see R08
      s_nxt.cnt = '0;
    end else if (tick) begin
      s_nxt.cnt = s_r.cnt + 1'b1; // see R08
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign level_out = s_r.out;

  a_delay_zero: assert property (@(posedge clk) disable iff (!nrst) // see R08
    (dly_eff == '0 && level_in != level_out) |=> (level_out == $past(level_in)))
    else $error("zero delay output did not follow source");
  a_delay_early: assert property (@(posedge clk) disable iff (!nrst) // see R08
    (level_in != level_out && s_r.cnt < dly_eff) |=> (level_out == $past(level_out)))
    else $error("output changed before its delay expired");
endmodule : off_delay

// [core/event_counter_timer.sv]
/*
  event counter and interval timer with routed, off-delayed switch and relay outputs.
  assumes count_event and drive_running are pins (synchronised here); all settings are held ports.
*/
`timescale 1ns/1ps
module event_counter_timer #(
  parameter int TENTH_CYCLES = evt_pkg::TENTH_CYCLES_DEF
) (
  input wire logic clk,
  input wire logic nrst,
  input wire logic count_event,
  input wire logic drive_running,
  input wire evt_pkg::end_mode_type cnt_mode,
  input wire evt_pkg::start_type cnt_start,
  input wire logic [evt_pkg::CNT_W-1:0] cnt_reset_value,
  input wire logic [evt_pkg::CNT_W-1:0] cnt_detect_value,
  input wire logic cnt_clear,
  input wire evt_pkg::end_mode_type tmr_mode,
  input wire evt_pkg::start_type tmr_start,
  input wire logic [evt_pkg::TMR_W-1:0] tmr_interval,
  input wire logic tmr_clear,
  input wire evt_pkg::out_src_type src_switch_a,
  input wire evt_pkg::out_src_type src_switch_b,
  input wire evt_pkg::out_src_type src_relay_a,
  input wire evt_pkg::out_src_type src_relay_b,
  input wire logic [evt_pkg::DLY_W-1:0] delay_switch_a,
  input wire logic [evt_pkg::DLY_W-1:0] delay_switch_b,
  input wire logic [evt_pkg::DLY_W-1:0] delay_relay_a,
  input wire logic [evt_pkg::DLY_W-1:0] delay_relay_b,
  output logic cnt_reset_out,
  output logic cnt_detect_out,
  output logic tmr_reach_out,
  output logic [evt_pkg::CNT_W-1:0] count_value,
  output logic [evt_pkg::TMR_W-1:0] timer_seconds,
  output logic switch_output_a,
  output logic switch_output_b,
  output logic relay_output_a,
  output logic relay_output_b
);
  import evt_pkg::*;

  localparam int TICK_W = $clog2(TENTH_CYCLES + 1);
  localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TENTH_CYCLES - 1);

  typedef struct packed {
    logic [1:0] ev_sync;
    logic [1:0] run_sync;
    logic ev_prev;
    logic [CNT_W-1:0] cnt;
    logic cnt_done;
    logic cnt_hit;
    logic cnt_det;
    logic [TICK_W-1:0] tick_cnt;
    logic tick;
    logic [3:0] tenth;
    logic [TMR_W-1:0] sec;
    logic tmr_done;
    logic tmr_hit;
  } state_type;

  state_type s_r;
  state_type s_nxt;
  logic running;
  logic ev_edge;
  logic cnt_en;
  logic tmr_en;
  logic [CNT_W-1:0] det_eff;
  logic [NUM_OUT-1:0] out_level;
  logic [NUM_OUT-1:0] out_pin;
  out_src_type out_src [NUM_OUT];
  logic [DLY_W-1:0] out_dly [NUM_OUT];

  // true when one more step makes value equal to target
  function automatic logic next_hits(input logic [15:0] value, input logic [15:0] target);
    next_hits = ({1'b0, value} + 17'h00001) == {1'b0, target};
  endfunction : next_hits

  function automatic logic pick_src(input out_src_type src, input logic hit, input logic det,
                                    input logic tmr);
    case (src)
      SRC_CNT_RESET: pick_src = hit;
      SRC_CNT_DETECT: pick_src = det;
      SRC_TMR_REACH: pick_src = tmr;
      default: pick_src = 1'b0;
    endcase
  endfunction : pick_src

  assign running = s_r.run_sync[1];
  assign ev_edge = s_r.ev_sync[1] & ~s_r.ev_prev;
  assign det_eff = (cnt_detect_value > cnt_reset_value) ? cnt_reset_value : cnt_detect_value; // see R04
  assign cnt_en = !s_r.cnt_done && (cnt_start == START_ALWAYS || running) // see R02
    && !(cnt_mode == END_CYCLE_HOLD && !running); // see R01
  assign tmr_en = !s_r.tmr_done && (tmr_start == START_ALWAYS || running) // see R06
    && (tmr_interval != '0); // see R07

  always_comb begin
    s_nxt = s_r;
    s_nxt.ev_sync = {s_r.ev_sync[0], count_event};
    s_nxt.run_sync = {s_r.run_sync[0], drive_running};
    s_nxt.ev_prev = s_r.ev_sync[1];
    // tenth-second tick
    s_nxt.tick = 1'b0;
    if (s_r.tick_cnt == TICK_LAST) begin
      s_nxt.tick_cnt = '0;
      s_nxt.tick = 1'b1;
    end else begin
      s_nxt.tick_cnt = s_r.tick_cnt + 1'b1;
    end
    // counter
    s_nxt.cnt_hit = s_r.cnt_hit && s_r.cnt_done && (cnt_mode == END_STOP_HOLD); // see R01, see R10
    s_nxt.cnt_det = 1'b0;
    if (cnt_clear) begin
      s_nxt.cnt = '0;
      s_nxt.cnt_done = 1'b0;
      s_nxt.cnt_hit = 1'b0;
    end else if (ev_edge && cnt_en) begin
      s_nxt.cnt_det = next_hits(s_r.cnt, det_eff); // see R09
      if (next_hits(s_r.cnt, cnt_reset_value)) begin
        s_nxt.cnt = '0; // see R03
        s_nxt.cnt_hit = 1'b1; // see R03
        s_nxt.cnt_done = (cnt_mode == END_STOP_OFF) || (cnt_mode == END_STOP_HOLD); // see R01, see R10
      end else begin
        s_nxt.cnt = s_r.cnt + 1'b1;
      end
    end
    // timer
    s_nxt.tmr_hit = s_r.tmr_hit && tmr_mode[0]; // see R05
    if (tmr_clear) begin
      s_nxt.sec = '0;
      s_nxt.tenth = '0;
      s_nxt.tmr_done = 1'b0;
      s_nxt.tmr_hit = 1'b0;
    end else if (tmr_en && s_r.tick) begin
      if (s_r.tenth == TENTHS_PER_SEC - 4'h1) begin
        s_nxt.tenth = '0;
        if (next_hits(s_r.sec, tmr_interval)) begin
          s_nxt.sec = '0;
          s_nxt.tmr_hit = 1'b1; // see R05
          s_nxt.tmr_done = !tmr_mode[1]; // see R05
        end else begin
          s_nxt.sec = s_r.sec + 1'b1; // see R07
        end
      end else begin
        s_nxt.tenth = s_r.tenth + 4'h1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign cnt_reset_out = s_r.cnt_hit;
  assign cnt_detect_out = s_r.cnt_det;
  assign tmr_reach_out = s_r.tmr_hit;
  assign count_value = s_r.cnt;
  assign timer_seconds = s_r.sec;

  assign out_src[0] = src_switch_a;
  assign out_src[1] = src_switch_b;
  assign out_src[2] = src_relay_a;
  assign out_src[3] = src_relay_b;
  assign out_dly[0] = delay_switch_a;
  assign out_dly[1] = delay_switch_b;
  assign out_dly[2] = delay_relay_a;
  assign out_dly[3] = delay_relay_b;

  for (genvar i = 0; i < NUM_OUT; i++) begin : g_out
    assign out_level[i] = pick_src(out_src[i], s_r.cnt_hit, s_r.cnt_det, s_r.tmr_hit);
    off_delay i_off_delay (
      .clk(clk),
      .nrst(nrst),
      .tick(s_r.tick),
      .level_in(out_level[i]),
      .delay_tenths(out_dly[i]),
      .level_out(out_pin[i])
    );
  end

  assign switch_output_a = out_pin[0];
  assign switch_output_b = out_pin[1];
  assign relay_output_a = out_pin[2];
  assign relay_output_b = out_pin[3];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_cnt_reach_clear: assert property ((ev_edge && cnt_en && !cnt_clear // see R03
    && next_hits(s_r.cnt, cnt_reset_value)) |=> (cnt_reset_out && s_r.cnt == '0))
    else $error("reset value reached without pulse and clear");
  a_cnt_stop_hold: assert property ((cnt_reset_out && s_r.cnt_done && cnt_mode == END_STOP_HOLD // see R01
    && !cnt_clear) |=> (cnt_reset_out && $stable(s_r.cnt)))
    else $error("stop-hold counter did not keep output");
  a_cnt_mode0_rel: assert property ((cnt_reset_out && cnt_mode == END_STOP_OFF) // see R10
    |=> (!cnt_reset_out && s_r.cnt == '0))
    else $error("mode 0 counter kept output or counted on");
  a_cnt_run_gate: assert property ((cnt_start == START_RUN && !running) // see R02
    |=> (s_r.cnt == $past(s_r.cnt) || $past(cnt_clear)))
    else $error("counter moved while drive stopped");
  a_det_clamp: assert property ((cnt_detect_value > cnt_reset_value && ev_edge && cnt_en // see R04
    && !cnt_clear && next_hits(s_r.cnt, cnt_reset_value)) |=> (cnt_detect_out && cnt_reset_out))
    else $error("detection value not limited to reset value");
  a_det_pulse: assert property ((ev_edge && cnt_en && !cnt_clear // see R09
    && next_hits(s_r.cnt, det_eff)) |=> cnt_detect_out ##1 !cnt_detect_out || ev_edge)
    else $error("detection output missing");
  a_tmr_cycle_rel: assert property ((tmr_reach_out && tmr_mode == END_CYCLE_OFF) // see R05
    |=> !tmr_reach_out [*2])
    else $error("cycle-release timer kept output");
  a_tmr_run_gate: assert property ((tmr_start == START_RUN && !running && !tmr_clear) // see R06
    |=> (s_r.sec == $past(s_r.sec) && s_r.tenth == $past(s_r.tenth)))
    else $error("timer moved while drive stopped");
  a_tmr_zero_idle: assert property ((tmr_interval == '0 && !tmr_clear) // see R07
    |=> (s_r.sec == $past(s_r.sec) && !tmr_reach_out || $past(tmr_reach_out)))
    else $error("timer advanced with zero interval");
  a_cnt_cycle_rel: assert property ((cnt_reset_out && cnt_mode == END_CYCLE_OFF) // see R01
    |=> !cnt_reset_out)
    else $error("cycle-release counter kept output");
  a_tmr_hold_out: assert property ((tmr_reach_out && tmr_mode[0] && !tmr_clear) // see R05
    |=> tmr_reach_out)
    else $error("holding timer dropped its output");
endmodule : event_counter_timer

// [testbench/drive_side_model.sv]
/*
  drive-side partner: makes counted event pulses and the run state, and counts the cycles each output is high.
  assumes the design samples on the rising edge; this model changes its pins on the falling edge.
*/
`timescale 1ns/1ps
module drive_side_model (
  input wire logic clk,
  input wire logic cnt_reset_out,
  input wire logic cnt_detect_out,
  input wire logic tmr_reach_out,
  output logic count_event,
  output logic drive_running
);
  int n_rst;
  int n_det;
  int n_tmr;
  initial begin
    count_event = 1'b0;
    drive_running = 1'b0;
    n_rst = 0;
    n_det = 0;
    n_tmr = 0;
  end
  // clock cycles with each output high, as seen by the drive
  always @(posedge clk) begin
    if (cnt_reset_out === 1'b1) n_rst++;
    if (cnt_detect_out === 1'b1) n_det++;
    if (tmr_reach_out === 1'b1) n_tmr++;
  end
  // each event is high 3 cycles and low 4 before the next (3 after the last), above the 2-cycle minimum
  task automatic events(input int n);
    repeat (n) begin
      @(negedge clk) count_event = 1'b1;
      repeat (3) @(negedge clk);
      count_event = 1'b0;
      repeat (3) @(negedge clk);
    end
  endtask : events
  task automatic set_run(input logic r);
    @(negedge clk) drive_running = r;
  endtask : set_run
  task automatic zero();
    n_rst = 0;
    n_det = 0;
    n_tmr = 0;
  endtask : zero
endmodule : drive_side_model

// [testbench/event_counter_and_interval_timer_test.sv]
/*
  self-checking bench for the event counter, interval timer and output off-delays.
  assumes TENTH_CYCLES of 4, so one second is 40 clock cycles.
*/
`timescale 1ns/1ps
module event_counter_and_interval_timer_test;
  import evt_pkg::*;
  logic clk, nrst, count_event, drive_running, cnt_clear, tmr_clear;
  end_mode_type cnt_mode, tmr_mode;
  start_type cnt_start, tmr_start;
  logic [15:0] cnt_reset_value, cnt_detect_value, tmr_interval, count_value, timer_seconds;
  out_src_type src_sa, src_sb, src_ra, src_rb;
  logic [9:0] dly_sa, dly_sb, dly_ra, dly_rb;
  logic cnt_reset_out, cnt_detect_out, tmr_reach_out, sw_a, sw_b, rl_a, rl_b;
  int bad_count = 0;
  int n_checks = 0;
  event_counter_timer #(.TENTH_CYCLES(4)) i_event_counter_timer (.clk(clk), .nrst(nrst),
    .count_event(count_event), .drive_running(drive_running), .cnt_mode(cnt_mode), .cnt_start(cnt_start),
    .cnt_reset_value(cnt_reset_value), .cnt_detect_value(cnt_detect_value), .cnt_clear(cnt_clear),
    .tmr_mode(tmr_mode), .tmr_start(tmr_start), .tmr_interval(tmr_interval), .tmr_clear(tmr_clear),
    .src_switch_a(src_sa), .src_switch_b(src_sb), .src_relay_a(src_ra), .src_relay_b(src_rb),
    .delay_switch_a(dly_sa), .delay_switch_b(dly_sb), .delay_relay_a(dly_ra), .delay_relay_b(dly_rb),
    .cnt_reset_out(cnt_reset_out), .cnt_detect_out(cnt_detect_out), .tmr_reach_out(tmr_reach_out),
    .count_value(count_value), .timer_seconds(timer_seconds), .switch_output_a(sw_a),
    .switch_output_b(sw_b), .relay_output_a(rl_a), .relay_output_b(rl_b));
  drive_side_model i_drive_side_model (.clk(clk), .cnt_reset_out(cnt_reset_out),
    .cnt_detect_out(cnt_detect_out), .tmr_reach_out(tmr_reach_out), .count_event(count_event),
    .drive_running(drive_running));
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk_val
  task automatic chk_bit(input logic got, input logic exp);
    chk_val({15'h0000, got}, {15'h0000, exp});
  endtask : chk_bit
  task automatic end_of_test();
    if (bad_count == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_of_test
  // set the counter, clear it and zero the pulse tallies
  task automatic cfg_cnt(input end_mode_type m, input start_type s, input logic [15:0] rv, input logic [15:0] dv);
    @(negedge clk) begin
      cnt_mode = m;
      cnt_start = s;
      cnt_reset_value = rv;
      cnt_detect_value = dv;
      cnt_clear = 1'b1;
    end
    @(negedge clk) cnt_clear = 1'b0;
    i_drive_side_model.zero();
  endtask : cfg_cnt
  task automatic cfg_tmr(input end_mode_type m, input start_type s, input logic [15:0] iv);
    @(negedge clk) begin
      tmr_mode = m;
      tmr_start = s;
      tmr_interval = iv;
      tmr_clear = 1'b1;
    end
    @(negedge clk) tmr_clear = 1'b0;
    i_drive_side_model.zero();
  endtask : cfg_tmr
  initial begin
    #40000;
    bad_count++;
    end_of_test();
  end
  initial begin
    nrst = 1'b0;
    {cnt_clear, tmr_clear} = 2'b00;
    cnt_mode = CNT_MODE_DEF;
    cnt_start = CNT_START_DEF;
    cnt_reset_value = CNT_RESET_DEF;
    cnt_detect_value = CNT_DETECT_DEF;
    tmr_mode = TMR_MODE_DEF;
    tmr_start = TMR_START_DEF;
    tmr_interval = TMR_INTERVAL_DEF;
    src_sa = SRC_TMR_REACH;
    src_sb = SRC_CNT_RESET;
    src_ra = SRC_TMR_REACH;
    src_rb = SRC_CNT_RESET;
    dly_sa = 10'h003;
    dly_sb = 10'h000;
    dly_ra = 10'h000;
    dly_rb = 10'h005;
    repeat (8) @(negedge clk);
    nrst = 1'b1;
    cfg_cnt(END_CYCLE_OFF, START_ALWAYS, 16'h0003, 16'h0002);
    i_drive_side_model.events(2);
    chk_val(count_value, 16'h0002);
    chk_val(16'(i_drive_side_model.n_det), 16'h0001);
    chk_val(16'(i_drive_side_model.n_rst), 16'h0000);
    i_drive_side_model.events(4);
    chk_val(count_value, 16'h0000);
    chk_val(16'(i_drive_side_model.n_rst), 16'h0002);
    chk_val(16'(i_drive_side_model.n_det), 16'h0002);
    cfg_cnt(END_STOP_HOLD, START_ALWAYS, 16'h0002, 16'h0000);
    i_drive_side_model.events(3);
    chk_val(count_value, 16'h0000);
    chk_bit(cnt_reset_out, 1'b1);
    chk_bit(sw_b, 1'b1);
    chk_bit(rl_b, 1'b0);
    repeat (16) @(negedge clk);
    chk_bit(rl_b, 1'b1);
    src_sb = SRC_NONE;
    repeat (2) @(negedge clk);
    chk_bit(sw_b, 1'b0);
    cfg_cnt(END_STOP_OFF, START_ALWAYS, 16'h0002, 16'h0000);
    i_drive_side_model.events(3);
    chk_val(count_value, 16'h0000);
    chk_bit(cnt_reset_out, 1'b0);
    chk_val(16'(i_drive_side_model.n_rst), 16'h0001);
    cfg_cnt(END_CYCLE_OFF, START_RUN, 16'h0064, 16'h0000);
    i_drive_side_model.events(2);
    chk_val(count_value, 16'h0000);
    i_drive_side_model.set_run(1'b1);
    i_drive_side_model.events(2);
    chk_val(count_value, 16'h0002);
    i_drive_side_model.set_run(1'b0);
    i_drive_side_model.events(1);
    chk_val(count_value, 16'h0002);
    cfg_cnt(END_CYCLE_HOLD, START_ALWAYS, 16'h0064, 16'h0000);
    i_drive_side_model.events(2);
    chk_val(count_value, 16'h0000);
    i_drive_side_model.set_run(1'b1);
    i_drive_side_model.events(1);
    chk_val(count_value, 16'h0001);
    cfg_cnt(END_CYCLE_OFF, START_ALWAYS, 16'h0003, 16'h0005);
    i_drive_side_model.events(3);
    chk_val(16'(i_drive_side_model.n_det), 16'h0001);
    cfg_tmr(END_CYCLE_OFF, START_ALWAYS, 16'h0000);
    repeat (150) @(negedge clk);
    chk_val(16'(i_drive_side_model.n_tmr), 16'h0000);
    cfg_tmr(END_CYCLE_OFF, START_ALWAYS, 16'h0001);
    repeat (130) @(negedge clk);
    chk_val(16'(i_drive_side_model.n_tmr), 16'h0003);
    cfg_tmr(END_STOP_OFF, START_ALWAYS, 16'h0001);
    repeat (130) @(negedge clk);
    chk_val(16'(i_drive_side_model.n_tmr), 16'h0001);
    cfg_tmr(END_STOP_HOLD, START_ALWAYS, 16'h0001);
    repeat (60) if (tmr_reach_out !== 1'b1) @(negedge clk);
    chk_val(timer_seconds, 16'h0000);
    chk_bit(rl_a, 1'b0);
    repeat (2) @(negedge clk);
    chk_bit(rl_a, 1'b1);
    chk_bit(sw_a, 1'b0);
    repeat (20) @(negedge clk);
    chk_bit(sw_a, 1'b1);
    chk_bit(tmr_reach_out, 1'b1);
    i_drive_side_model.set_run(1'b0);
    cfg_tmr(END_CYCLE_HOLD, START_RUN, 16'h0001);
    repeat (100) @(negedge clk);
    chk_bit(tmr_reach_out, 1'b0);
    i_drive_side_model.set_run(1'b1);
    repeat (130) @(negedge clk);
    chk_bit(tmr_reach_out, 1'b1);
    end_of_test();
  end
endmodule : event_counter_and_interval_timer_test
